/* File: hdl/iso_desc_consts.vh */
// Descriptor field positions, register offsets and timing for the iso descriptor engine
`ifndef ISO_DESC_CONSTS_VH
`define ISO_DESC_CONSTS_VH
// Descriptor fields (320-bit descriptor, word n at bits 64n+63..64n)
`define DW0_VALID 0
`define DW0_BYTES_REQ_LO 3
`define DW0_MAX_PAYLOAD_LO 18
`define DW0_MULT_LO 29
`define DW0_EP_LSB 31
`define DW1_EP_HI_LO 32
`define DW1_ADDR_LO 35
`define DW1_TOKEN_LO 42
`define DW1_KIND_LO 44
`define DW1_SPLIT 46
`define DW2_FRAME_LO 3
`define DW2_PTR_LO 8
`define DW3_DONE_LO 32
`define DW3_HALT 62
`define DW3_ACTIVE 63
`define DW4_MASK_LO 0
`define DW4_RESULT_LO 8
// Token codes
`define TOKEN_OUT 2'h0
`define TOKEN_IN 2'h1
// Result bits
`define RES_XERR 0
`define RES_BABBLE 1
`define RES_UNDERRUN 2
// Register word offsets (byte addresses)
`define REG_DW0 8'h00
`define REG_DW1 8'h04
`define REG_DW2 8'h08
`define REG_DW3 8'h0C
`define REG_DW4 8'h10
`define REG_CTRL 8'h14
`define REG_FRAME 8'h18
`define REG_IRQ_STAT 8'h1C
`define REG_IRQ_MASK 8'h20
`define REG_ENGINE 8'h24
`define REG_PKT 8'h28
// Interrupt status bits
`define IRQ_DONE 0
`define IRQ_HALT 1
`define IRQ_ERR 2
`define IRQ_PKT 3
`define IRQ_W 4
// Bus behaviour of the ack pulse handshake
`define ACK_LATENCY 1
`endif

/* File: hdl/pkt_counter.v */
// Packet/byte accumulator for one descriptor execution
module pkt_counter #(
   parameter CW = 15
) (
   input wire clk_i,
   input wire rst_i,
   input wire start_i,
   input wire add_i,
   input wire [10:0] bytes_i,
   output reg [CW-1:0] total_o,
   output reg [1:0] pkts_o
);
   // Clear at execution start, accumulate per packet
   always @(posedge clk_i) begin
      if (rst_i || start_i) begin
         total_o <= {CW{1'b0}};
         pkts_o <= 2'h0;
      end else if (add_i) begin
         total_o <= total_o + {{(CW-11){1'b0}}, bytes_i};
         pkts_o <= pkts_o + 2'h1;
      end
   end
endmodule

/* File: hdl/iso_desc_engine.v */
// High-speed isochronous descriptor engine with Wishbone register access
// Notes on behaviour
// - Active flag acts as the valid flag; the code also needs DW0 bit 0 set
// - One halt flag for whole millisecond
// - Endpoint stall sets halt, clears valid
// - Write actual byte count to done field
// - Intermediate totals allowed when multiplier above one
// - Payload pointer is internal buffer address
// - Match only frame number bits 4 to 0, against descriptor bits 7 to 3
// - Bit 46 selects split or direct
// - Token 00 is OUT, 01 is IN
// - Function address from bits 41 to 35
// - Endpoint is bits 34:32 plus bit 31
// - Up to multiplier packets per execution
// - Run only active microframes, clear after
// - Record error, babble, underrun per microframe
// - Clear valid when done or fatal error
//
// Register access over Wishbone and the register addresses were left to the implementer.
`include "iso_desc_consts.vh"
module iso_desc_engine (
   input wire clk_i,
   input wire rst_i,
   // Wishbone slave
   input wire cyc_i,
   input wire stb_i,
   input wire we_i,
   input wire [7:0] adr_i,
   input wire [3:0] sel_i,
   input wire [31:0] dat_i,
   output reg [31:0] dat_o,
   output reg ack_o,
   output reg irq_o,
   // Bus frame timing
   input wire uframe_strobe_i,
   input wire [10:0] frame_num_i,
   input wire [2:0] uframe_num_i,
   // Transaction request to the link
   output reg txn_req_o,
   output reg txn_is_in_o,
   output reg txn_split_o,
   output reg [6:0] txn_addr_o,
   output reg [3:0] txn_ep_o,
   output reg [15:0] txn_ptr_o,
   output reg [10:0] txn_max_o,
   // Transaction answer from the link
   input wire txn_done_i,
   input wire [10:0] txn_bytes_i,
   input wire txn_xerr_i,
   input wire txn_babble_i,
   input wire txn_underrun_i,
   input wire txn_stall_i,
   input wire txn_fatal_i
);
   localparam S_IDLE = 3'b001;
   localparam S_REQ = 3'b010;
   localparam S_WAIT = 3'b100;

   reg [63:0] dw0_q, dw1_q, dw2_q, dw3_q, dw4_q;
   reg [2:0] state_q;
   reg [3:0] irq_stat_q;
   reg [3:0] irq_mask_q;
   reg [2:0] uf_q;
   reg [1:0] want_q;
   reg [15:0] ptr_q;
   reg [10:0] bytes_q; // Packet size held for the accumulator
   reg exec_start;
   reg pkt_add;
   wire [14:0] total;
   wire [1:0] pkts;
   wire bus_req = cyc_i && stb_i && !ack_o;
   wire bus_wr = bus_req && we_i;
   reg [3:0] ev_set;

   // Merge a word with byte enables
   function [31:0] merge;
      input [31:0] old;
      input [31:0] nw;
      input [3:0] sel;
      integer k;
      begin
         merge = old;
         for (k = 0; k < 4; k = k + 1)
            if (sel[k]) merge[k*8 +: 8] = nw[k*8 +: 8];
      end
   endfunction

   wire valid = dw0_q[`DW0_VALID] && dw3_q[`DW3_ACTIVE];
   wire [1:0] mult = dw0_q[`DW0_MULT_LO +: 2];
   wire frame_hit = dw2_q[`DW2_FRAME_LO +: 5] == frame_num_i[4:0];
   wire uf_on = dw4_q[`DW4_MASK_LO + uframe_num_i];

   pkt_counter #(.CW(15)) u_cnt (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .start_i(exec_start),
      .add_i(pkt_add),
      .bytes_i(bytes_q),
      .total_o(total),
      .pkts_o(pkts)
   );

   // Wishbone ack, one cycle after request
   always @(posedge clk_i) begin
      if (rst_i) ack_o <= 1'b0;
      else ack_o <= bus_req;
   end

   // Read mux
   always @(posedge clk_i) begin
      if (rst_i) begin
         dat_o <= 32'h0;
      end else if (bus_req && !we_i) begin
         case (adr_i)
            `REG_DW0: dat_o <= dw0_q[31:0];
            `REG_DW1: dat_o <= dw1_q[63:32];
            `REG_DW2: dat_o <= dw2_q[31:0];
            `REG_DW3: dat_o <= dw3_q[63:32];
            `REG_DW4: dat_o <= dw4_q[31:0];
            `REG_CTRL: dat_o <= {31'h0, valid};
            `REG_FRAME: dat_o <= {21'h0, frame_num_i};
            `REG_IRQ_STAT: dat_o <= {28'h0, irq_stat_q};
            `REG_IRQ_MASK: dat_o <= {28'h0, irq_mask_q};
            `REG_ENGINE: dat_o <= {26'h0, uf_q, state_q};
            `REG_PKT: dat_o <= {15'h0, pkts, total};
            default: dat_o <= 32'h0;
         endcase
      end
   end

   // Interrupt status: set wins over write-one clear
   always @(posedge clk_i) begin
      if (rst_i) begin
         irq_stat_q <= 4'h0;
         irq_mask_q <= 4'h0;
         irq_o <= 1'b0;
      end else begin
         if (bus_wr && adr_i == `REG_IRQ_MASK && sel_i[0]) irq_mask_q <= dat_i[3:0];
         if (bus_wr && adr_i == `REG_IRQ_STAT && sel_i[0])
            irq_stat_q <= (irq_stat_q & ~dat_i[3:0]) | ev_set;
         else
            irq_stat_q <= irq_stat_q | ev_set;
         irq_o <= |((irq_stat_q | ev_set) & irq_mask_q);
      end
   end

   // Descriptor storage, engine and write-back
   always @(posedge clk_i) begin
      exec_start <= 1'b0;
      pkt_add <= 1'b0;
      ev_set <= 4'h0;
      if (rst_i) begin
         dw0_q <= 64'h0;
         dw1_q <= 64'h0;
         dw2_q <= 64'h0;
         dw3_q <= 64'h0;
         dw4_q <= 64'h0;
         state_q <= S_IDLE;
         uf_q <= 3'h0;
         want_q <= 2'h0;
         ptr_q <= 16'h0;
         bytes_q <= 11'h0;
         txn_req_o <= 1'b0;
         txn_is_in_o <= 1'b0;
         txn_split_o <= 1'b0;
         txn_addr_o <= 7'h0;
         txn_ep_o <= 4'h0;
         txn_ptr_o <= 16'h0;
         txn_max_o <= 11'h0;
      end else begin
         // Software writes (only while engine idle)
         if (bus_wr && state_q == S_IDLE) begin
            case (adr_i)
               `REG_DW0: dw0_q[31:0] <= merge(dw0_q[31:0], dat_i, sel_i);
               `REG_DW1: dw1_q[63:32] <= merge(dw1_q[63:32], dat_i, sel_i);
               `REG_DW2: dw2_q[31:0] <= merge(dw2_q[31:0], dat_i, sel_i);
               `REG_DW3: dw3_q[63:32] <= merge(dw3_q[63:32], dat_i, sel_i);
               `REG_DW4: dw4_q[31:0] <= merge(dw4_q[31:0], dat_i, sel_i);
               default: ;
            endcase
         end
         case (state_q)
            S_IDLE: begin
               // Invalid descriptors are skipped untouched
               if (uframe_strobe_i && valid && frame_hit && uf_on) begin
                  exec_start <= 1'b1;
                  uf_q <= uframe_num_i;
                  want_q <= (mult == 2'h0) ? 2'h1 : mult;
                  ptr_q <= dw2_q[`DW2_PTR_LO +: 16];
                  state_q <= S_REQ;
               end
            end
            S_REQ: begin
               txn_req_o <= 1'b1;
               txn_is_in_o <= dw1_q[`DW1_TOKEN_LO +: 2] == `TOKEN_IN;
               txn_split_o <= dw1_q[`DW1_SPLIT];
               txn_addr_o <= dw1_q[`DW1_ADDR_LO +: 7];
               txn_ep_o <= {dw1_q[`DW1_EP_HI_LO +: 3], dw0_q[`DW0_EP_LSB]};
               txn_ptr_o <= ptr_q;
               txn_max_o <= dw0_q[`DW0_MAX_PAYLOAD_LO +: 11];
               state_q <= S_WAIT;
            end
            S_WAIT: begin
               if (txn_done_i) begin
                  txn_req_o <= 1'b0;
                  pkt_add <= 1'b1;
                  bytes_q <= txn_bytes_i; // Link lines are only valid with done
                  ev_set[`IRQ_PKT] <= 1'b1;
                  // Intermediate total after each packet
                  dw3_q[`DW3_DONE_LO +: 15] <= total + {4'h0, txn_bytes_i};
                  // Per-microframe result
                  dw4_q[`DW4_RESULT_LO + uf_q*3 +: 3] <= {txn_underrun_i, txn_babble_i, txn_xerr_i};
                  if (txn_xerr_i || txn_babble_i || txn_underrun_i) ev_set[`IRQ_ERR] <= 1'b1;
                  ptr_q <= ptr_q + {8'h0, txn_bytes_i[10:3]} + {15'h0, |txn_bytes_i[2:0]};
                  if (txn_stall_i) begin
                     dw3_q[`DW3_HALT] <= 1'b1;
                     dw0_q[`DW0_VALID] <= 1'b0;
                     dw3_q[`DW3_ACTIVE] <= 1'b0;
                     dw4_q[`DW4_MASK_LO + uf_q] <= 1'b0;
                     ev_set[`IRQ_HALT] <= 1'b1;
                     state_q <= S_IDLE;
                  end else if (txn_fatal_i) begin
                     dw0_q[`DW0_VALID] <= 1'b0;
                     dw3_q[`DW3_ACTIVE] <= 1'b0;
                     dw4_q[`DW4_MASK_LO + uf_q] <= 1'b0;
                     ev_set[`IRQ_ERR] <= 1'b1;
                     state_q <= S_IDLE;
                  end else if (pkts + 2'h1 >= want_q || txn_bytes_i < txn_max_o) begin
                     dw4_q[`DW4_MASK_LO + uf_q] <= 1'b0;
                     if ((dw4_q[`DW4_MASK_LO +: 8] & ~(8'h01 << uf_q)) == 8'h00) begin
                        dw0_q[`DW0_VALID] <= 1'b0;
                        dw3_q[`DW3_ACTIVE] <= 1'b0;
                        ev_set[`IRQ_DONE] <= 1'b1;
                     end
                     state_q <= S_IDLE;
                  end else begin
                     state_q <= S_REQ;
                  end
               end
            end
            default: state_q <= S_IDLE;
         endcase
      end
   end
endmodule

/* File: sim/iso_desc_engine_checker.sv */
// Bus and link timing checker for the iso descriptor engine
module iso_desc_engine_checker (
   input wire logic clk_i, rst_i, cyc_i, stb_i, ack_o, irq_o, uframe_strobe_i,
   input wire logic txn_req_o, txn_is_in_o, txn_split_o, txn_done_i, txn_stall_i, txn_fatal_i,
   input wire logic [6:0] txn_addr_o,
   input wire logic [3:0] txn_ep_o,
   input wire logic [15:0] txn_ptr_o,
   input wire logic [10:0] txn_max_o, txn_bytes_i
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   // Bus handshake
   AST_ACK_RESP: assert property (cyc_i && stb_i && !ack_o |=> ack_o) else $error("bus cycle not acknowledged");
   AST_ACK_PULSE: assert property (ack_o |=> !ack_o) else $error("ack longer than one cycle");
   // Link request life
   AST_REQ_DROP: assert property (txn_req_o && txn_done_i |=> !txn_req_o) else $error("request held after done");
   AST_REQ_HOLD: assert property (
      txn_req_o && !txn_done_i |=> txn_req_o && $stable({txn_is_in_o, txn_split_o, txn_addr_o, txn_ep_o,
      txn_ptr_o, txn_max_o})) else $error("request fields moved");
   AST_REQ_CAUSE: assert property (
      $rose(txn_req_o) |-> $past(uframe_strobe_i, 2) || $past(txn_done_i, 2)) else $error("request without cause");
   AST_STALL_STOP: assert property (
      txn_done_i && txn_stall_i |=> !txn_req_o [*8]) else $error("request after stall");
   AST_FATAL_STOP: assert property (
      txn_done_i && txn_fatal_i |=> !txn_req_o [*8]) else $error("request after fatal error");
   AST_SHORT_END: assert property (
      txn_done_i && txn_bytes_i < txn_max_o |=> !txn_req_o [*4]) else $error("request after short packet");
   // Main scenarios
   cover property (txn_done_i && txn_is_in_o && txn_split_o);
   cover property (txn_done_i && txn_stall_i);
   cover property ($rose(irq_o));
endmodule

bind iso_desc_engine iso_desc_engine_checker chk (.clk_i, .rst_i, .cyc_i, .stb_i, .ack_o, .irq_o,
   .uframe_strobe_i, .txn_req_o, .txn_is_in_o, .txn_split_o, .txn_done_i, .txn_stall_i, .txn_fatal_i,
   .txn_addr_o, .txn_ep_o, .txn_ptr_o, .txn_max_o, .txn_bytes_i);

/* File: sim/iso_link_partner.sv */
// Isochronous endpoint model answering link requests
module iso_link_partner (
   input wire logic clk_i, rst_i, req_i,
   input wire logic [10:0] max_i, short_i,
   input wire logic [1:0] full_i,
   input wire logic [3:0] lat_i,
   input wire logic [4:0] flags_i,
   output logic done_o,
   output logic [10:0] bytes_o,
   output logic [4:0] flags_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [3:0] wait_q;
   logic [2:0] idle_q;
   logic [1:0] pkt_q;
   // Answer after lat_i cycles; full packets first, then short; lines scramble between answers
   always @(posedge clk_i) begin
      done_o <= 1'b0;
      bytes_o <= ~bytes_o;
      flags_o <= ~flags_o;
      if (rst_i) begin
         wait_q <= 4'h0;
         idle_q <= 3'h0;
         pkt_q <= 2'h0;
         bytes_o <= 11'h2AA;
         flags_o <= 5'h0A;
      end else if (!req_i) begin
         wait_q <= 4'h0;
         if (idle_q == 3'h6) pkt_q <= 2'h0;
         else idle_q <= idle_q + 3'h1;
      end else if (!done_o) begin
         idle_q <= 3'h0;
         wait_q <= wait_q + 4'h1;
         if (wait_q == lat_i) begin
            done_o <= 1'b1;
            wait_q <= 4'h0;
            pkt_q <= pkt_q + 2'h1;
            bytes_o <= (pkt_q < full_i) ? max_i : short_i;
            flags_o <= flags_i;
         end
      end
   end
endmodule

/* File: sim/iso_desc_engine_test.sv */
// Register-level testbench of the iso descriptor engine
`include "iso_desc_consts.vh"
module iso_desc_engine_test;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0, uframe_strobe_i = 0, seen_q = 0;
   logic [7:0] adr_i = 0;
   logic [3:0] sel_i = 0, lat = 0, txn_ep_o;
   logic [31:0] dat_i = 0, dat_o, rd;
   logic [10:0] frame_num_i = 0, short_b = 0, txn_max_o, txn_bytes_i;
   logic [2:0] uframe_num_i = 0;
   logic [1:0] full_n = 0;
   logic [4:0] flg = 0, pf;
   logic [6:0] txn_addr_o;
   logic [15:0] txn_ptr_o, ptr_off = 0;
   logic [47:0] exp_f;
   logic ack_o, irq_o, txn_req_o, txn_is_in_o, txn_split_o, txn_done_i;
   int err_count = 0, n_compared = 0, n_req = 0, k;
   iso_desc_engine DUT (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .dat_o, .ack_o,
      .irq_o, .uframe_strobe_i, .frame_num_i, .uframe_num_i, .txn_req_o, .txn_is_in_o, .txn_split_o,
      .txn_addr_o, .txn_ep_o, .txn_ptr_o, .txn_max_o, .txn_done_i, .txn_bytes_i, .txn_xerr_i(pf[4]),
      .txn_babble_i(pf[3]), .txn_underrun_i(pf[2]), .txn_stall_i(pf[1]), .txn_fatal_i(pf[0]));
   iso_link_partner link (.clk_i, .rst_i, .req_i(txn_req_o), .max_i(txn_max_o), .short_i(short_b),
      .full_i(full_n), .lat_i(lat), .flags_i(flg), .done_o(txn_done_i), .bytes_o(txn_bytes_i), .flags_o(pf));
   // Clock
   initial begin
      forever #2.5 clk_i = ~clk_i;
   end
   task print_verdict;
      $display("compared %0d mismatches %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   task chk(input string nm, input logic [47:0] s, e);
      n_compared++;
      if (s !== e) begin
         err_count++;
         $display("[ERR] %s expected %h seen %h", nm, e, s);
      end
   endtask
   // One classic bus cycle, held until ack
   task wb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s = 4'hF);
      int n;
      @(posedge clk_i);
      cyc_i <= 1; stb_i <= 1; we_i <= w; adr_i <= a; dat_i <= d; sel_i <= s;
      for (n = 0; n < 20; n++) begin
         @(posedge clk_i);
         if (ack_o === 1'b1) break;
      end
      if (ack_o !== 1'b1) begin err_count++; print_verdict; end
      rd = dat_o;
      cyc_i <= 0; stb_i <= 0;
   endtask
   task rdchk(input string nm, input logic [7:0] a, input logic [31:0] e);
      wb(0, a, 0);
      chk(nm, rd, e);
   endtask
   task desc(input logic [31:0] w0, w1, w2, w4);
      wb(1, `REG_DW0, w0); wb(1, `REG_DW1, w1); wb(1, `REG_DW2, w2);
      wb(1, `REG_DW3, 32'h80000000); wb(1, `REG_DW4, w4);
   endtask
   // Microframe start, then poll until the engine is idle again
   task uf(input logic [10:0] f, input logic [2:0] u);
      int n;
      @(posedge clk_i);
      uframe_strobe_i <= 1; frame_num_i <= f; uframe_num_i <= u;
      @(posedge clk_i);
      uframe_strobe_i <= 0;
      for (n = 0; n < 40; n++) begin
         wb(0, `REG_ENGINE, 0);
         if (rd[2:0] === 3'h1) break;
      end
      if (n == 40) begin err_count++; print_verdict; end
   endtask
   // Check link fields at each new request
   always @(posedge clk_i) begin
      if (txn_req_o === 1'b1 && !seen_q) begin
         n_req++;
         chk("link", {txn_is_in_o, txn_split_o, txn_addr_o, txn_ep_o, txn_ptr_o, txn_max_o},
            exp_f + {21'h0, ptr_off, 11'h0});
      end
      // Buffer pointer advances by whole 8-byte units per packet
      if (uframe_strobe_i) ptr_off <= 16'h0;
      else if (txn_done_i === 1'b1) ptr_off <= ptr_off + 16'((txn_bytes_i + 11'd7) >> 3);
      seen_q <= (txn_req_o === 1'b1);
   end
   // Main sequence
   initial begin
      repeat (10) @(posedge clk_i);
      rst_i <= 0;
      rdchk("ctrl", `REG_CTRL, 0);
      rdchk("unmapped", 8'hFC, 0);
      wb(1, `REG_IRQ_MASK, 32'hF);
      exp_f = {8'h0, 2'b11, 7'h55, 4'hB, 16'h0180, 11'd16};
      full_n <= 1; short_b <= 5; lat <= 3;
      desc(32'hC043FFF9, 32'h56AD, 32'h18057, 32'h5);
      rdchk("ctrl", `REG_CTRL, 1);
      uf(11'h60A, 0);
      rdchk("count", `REG_DW3, 32'h80000015);
      rdchk("dw4", `REG_DW4, 32'h4);
      rdchk("pkt", `REG_PKT, 32'h10015);
      chk("irq", irq_o, 1);
      wb(1, `REG_IRQ_MASK, 0, 4'h2);
      rdchk("mask", `REG_IRQ_MASK, 32'hF);
      wb(1, `REG_IRQ_MASK, 0);
      wb(1, `REG_IRQ_STAT, 32'hF);
      uf(11'h60A, 1);
      flg <= 5'h10; full_n <= 0; short_b <= 3; lat <= 0;
      uf(11'h60A, 2);
      chk("irq", irq_o, 0);
      rdchk("dw4", `REG_DW4, 32'h4000);
      rdchk("ctrl", `REG_CTRL, 0);
      wb(1, `REG_IRQ_MASK, 32'hF);
      wb(0, `REG_IRQ_STAT, 0);
      chk("irq", irq_o, 1);
      wb(1, `REG_IRQ_STAT, 32'hF);
      wb(0, `REG_IRQ_STAT, 0);
      chk("irq", irq_o, 0);
      chk("requests", n_req, 3);
      for (k = 0; k < 2; k++) begin
         exp_f = {8'h0, 2'b00, 7'h12, 4'h0, 16'h0040, 11'd8};
         desc(32'h2023FFF9, 32'h1090, 32'h4018, 32'h1);
         uf(11'h00A, 0);
         rdchk("skip", `REG_DW3, 32'h80000000);
         flg <= k ? 5'h01 : 5'h02;
         uf(11'h7E3, 0);
         wb(0, `REG_DW3, 0);
         chk("halt", rd[31:30], k ? 2'b00 : 2'b01);
         rdchk("ctrl", `REG_CTRL, 0);
      end
      chk("requests", n_req, 5);
      print_verdict;
   end
endmodule
